// ==== logic/dds_ctrl_consts.vh ====
// Offsets, fields and encodings for the channel mode control block
// Assumes a 32-bit classic Wishbone slave, byte addresses, word aligned
`ifndef DDS_CTRL_CONSTS_VH
`define DDS_CTRL_CONSTS_VH
`define OFF_GLOBAL 8'h00
`define OFF_FUNC_ONE 8'h04
`define OFF_CH0 8'h10
`define OFF_CH1 8'h14
`define OFF_CH2 8'h18
`define OFF_CH3 8'h1C
`define OFF_UPDATE 8'h20
`define OFF_STATUS 8'h24
`define G_AUTO_PH 0
`define G_AUTO_SW 1
`define G_CLR_PH 2
`define G_CLR_SW 3
`define G_PD_CLKIN 4
`define G_PD_DACREF 5
`define G_PD_SYNC 6
`define G_PD_PIN_FULL 7
`define G_OPMODE 8
`define G_MATCH_PIPE 9
`define F1_LEVEL_LO 8
`define F1_LEVEL_HI 9
`define F1_RAMP_LO 10
`define F1_RAMP_HI 11
`define F1_PROF_CFG_LO 12
`define F1_PROF_CFG_HI 14
`define C_PD_DIG 0
`define C_PD_DAC 1
`define C_MOD_LO 2
`define C_MOD_HI 3
`define C_SWEEP_EN 4
`define C_NO_DWELL 5
`define C_RELOAD_RATE 6
`define C_CLR_SW 7
`define C_AUTO_SW 8
`define C_AUTO_PH 9
`define C_CLR_PH 10
`define C_RATE_LO 16
`define C_RATE_HI 23
`define RAMP_OFF 2'b00
`define RAMP_P23 2'b01
`define RAMP_P3 2'b10
`define RAMP_SDIO 2'b11
`define MOD_NONE 2'b00
`define MOD_AMP 2'b01
`define MOD_FREQ 2'b10
`define MOD_PHASE 2'b11
`define DAC_CHANNEL 1
`endif

// ==== logic/dds_channel_mode_control.v ====
// Control and configuration for a four-channel synthesizer core
// Assumes classic Wishbone master on CLK; PROFILE, SDIO and PD pins are asynchronous
// Functional notes
// - Auto-clear zeroes accumulator once, then resumes
// - Clear holds accumulator zero until released
// - Global clears act on all channels
// - Profile config field sits at bits 14:12
// - Profile bits reset zero, read written value
// - Ramp pins: P2&P3, P3, SDIO, disabled
// - Ramp disabled by default, no ramping
// - Level selects 2, 4, 8, 16 levels
// - Independent clock, DAC ref, sync power-downs
// - Pin mode: quick recovery or full down
// - Power-down pin high means powered down
// - Operational mode: spur reduction or test tone
// - Four channels, only channel one drives DAC
// - Per-channel digital and DAC power-down, reset clear
// - Channels without DAC: digital power-down only
// - Per-channel modulation type, global level
// - Sweep enable activates sweep and no-dwell
// - Reload copies ramp rate on update strobe
// - Per-channel sweep clears act locally
// - Matched pipe delays only in single tone
// - Match pipe delays resets cleared
// - Writes buffered until update strobe
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "dds_ctrl_consts.vh"
module dds_channel_mode_control (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire IO_UPDATE,
    input wire [3:0] PROFILE,
    input wire [3:0] SDIO,
    input wire PWR_DOWN_PIN,
    output reg [3:0] PH_ACC_ZERO,
    output reg [3:0] SW_ACC_ZERO,
    output reg [3:0] DIG_PD,
    output reg DAC_PD,
    output reg CLKIN_PD,
    output reg DACREF_PD,
    output reg SYNC_OUT_PD,
    output reg [2:0] PROFILE_PIN_CONFIG,
    output reg [3:0] MOD_LEVELS,
    output reg [7:0] CH_MOD_TYPE,
    output reg [3:0] SWEEP_EN,
    output reg [3:0] NO_DWELL,
    output reg [3:0] MATCH_PIPE,
    output reg TEST_TONE_MODE,
    output reg RAMP_ACTIVE,
    output reg RAMP_UP,
    output reg [3:0] RATE_LOAD,
    output reg [31:0] RATE_VALUE
);
    reg [31:0] buf_glob_r, act_glob_r;
    reg [31:0] buf_f1_r, act_f1_r;
    reg [31:0] buf_ch_r [0:3];
    reg [31:0] act_ch_r [0:3];
    reg [3:0] auto_ph_done_r, auto_sw_done_r;
    reg [3:0] prof_s1_r, prof_s2_r, sdio_s1_r, sdio_s2_r;
    reg pd_s1_r, pd_s2_r, upd_s1_r, upd_s2_r, upd_s3_r;
    wire upd_pulse = upd_s2_r & ~upd_s3_r;
    wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // Pin strobe and software strobe are treated alike everywhere
    wire sw_upd = bus_req & WB_WE_I & (WB_ADR_I == `OFF_UPDATE);
    wire upd_any = upd_pulse | sw_upd;
    integer i;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Pins are asynchronous to CLK
    always @(posedge CLK) begin
        prof_s1_r <= PROFILE;
        prof_s2_r <= prof_s1_r;
        sdio_s1_r <= SDIO;
        sdio_s2_r <= sdio_s1_r;
        pd_s1_r <= PWR_DOWN_PIN;
        pd_s2_r <= pd_s1_r;
        upd_s1_r <= IO_UPDATE;
        upd_s2_r <= upd_s1_r;
        upd_s3_r <= upd_s2_r;
    end

    // Bus writes land in buffers; active copies change only on update
    always @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            buf_glob_r <= 32'h0000_0000;
            act_glob_r <= 32'h0000_0000;
            buf_f1_r <= 32'h0000_0000;
            act_f1_r <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                buf_ch_r[i] <= 32'h0000_0000;
                act_ch_r[i] <= 32'h0000_0000;
            end
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req && WB_WE_I) begin
                case (WB_ADR_I)
                    `OFF_GLOBAL: buf_glob_r <= merge(buf_glob_r, WB_DAT_I, WB_SEL_I);
                    `OFF_FUNC_ONE: buf_f1_r <= merge(buf_f1_r, WB_DAT_I, WB_SEL_I);
                    `OFF_CH0: buf_ch_r[0] <= merge(buf_ch_r[0], WB_DAT_I, WB_SEL_I);
                    `OFF_CH1: buf_ch_r[1] <= merge(buf_ch_r[1], WB_DAT_I, WB_SEL_I);
                    `OFF_CH2: buf_ch_r[2] <= merge(buf_ch_r[2], WB_DAT_I, WB_SEL_I);
                    `OFF_CH3: buf_ch_r[3] <= merge(buf_ch_r[3], WB_DAT_I, WB_SEL_I);
                    default: ;
                endcase
            end
            // Software update register acts as a second strobe source
            if (upd_any) begin
                act_glob_r <= buf_glob_r;
                act_f1_r <= buf_f1_r;
                for (i = 0; i < 4; i = i + 1) begin
                    act_ch_r[i] <= buf_ch_r[i];
                end
            end
            WB_DAT_O <= 32'h0000_0000;
            if (bus_req && !WB_WE_I) begin
                case (WB_ADR_I)
                    `OFF_GLOBAL: WB_DAT_O <= buf_glob_r;
                    `OFF_FUNC_ONE: WB_DAT_O <= buf_f1_r;
                    `OFF_CH0: WB_DAT_O <= buf_ch_r[0];
                    `OFF_CH1: WB_DAT_O <= buf_ch_r[1];
                    `OFF_CH2: WB_DAT_O <= buf_ch_r[2];
                    `OFF_CH3: WB_DAT_O <= buf_ch_r[3];
                    `OFF_STATUS: WB_DAT_O <= {16'h0000, 3'b000, pd_s2_r, PH_ACC_ZERO,
                                              SW_ACC_ZERO, DIG_PD};
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Accumulator clear: hold-clear wins; auto-clear gives one zero pulse per setting
    always @(posedge CLK) begin
        if (RST) begin
            PH_ACC_ZERO <= 4'h0;
            SW_ACC_ZERO <= 4'h0;
            auto_ph_done_r <= 4'h0;
            auto_sw_done_r <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (act_glob_r[`G_CLR_PH] || act_ch_r[i][`C_CLR_PH]) begin
                    PH_ACC_ZERO[i] <= 1'b1;
                end else if ((act_glob_r[`G_AUTO_PH] || act_ch_r[i][`C_AUTO_PH])
                             && !auto_ph_done_r[i]) begin
                    PH_ACC_ZERO[i] <= 1'b1;
                end else begin
                    PH_ACC_ZERO[i] <= 1'b0;
                end
                if (act_glob_r[`G_CLR_SW] || act_ch_r[i][`C_CLR_SW]) begin
                    SW_ACC_ZERO[i] <= 1'b1;
                end else if ((act_glob_r[`G_AUTO_SW] || act_ch_r[i][`C_AUTO_SW])
                             && !auto_sw_done_r[i]) begin
                    SW_ACC_ZERO[i] <= 1'b1;
                end else begin
                    SW_ACC_ZERO[i] <= 1'b0;
                end
                // Re-arms when auto-clear is dropped or an update re-applies it
                auto_ph_done_r[i] <= (act_glob_r[`G_AUTO_PH] | act_ch_r[i][`C_AUTO_PH])
                                     & ~upd_any;
                auto_sw_done_r[i] <= (act_glob_r[`G_AUTO_SW] | act_ch_r[i][`C_AUTO_SW])
                                     & ~upd_any;
            end
        end
    end

    // Configuration outputs and ramp pin selection
    always @(posedge CLK) begin
        if (RST) begin
            DIG_PD <= 4'h0;
            DAC_PD <= 1'b0;
            CLKIN_PD <= 1'b0;
            DACREF_PD <= 1'b0;
            SYNC_OUT_PD <= 1'b0;
            PROFILE_PIN_CONFIG <= 3'b000;
            MOD_LEVELS <= 4'h1;
            CH_MOD_TYPE <= 8'h00;
            SWEEP_EN <= 4'h0;
            NO_DWELL <= 4'h0;
            MATCH_PIPE <= 4'h0;
            TEST_TONE_MODE <= 1'b0;
            RAMP_ACTIVE <= 1'b0;
            RAMP_UP <= 1'b0;
            RATE_LOAD <= 4'h0;
            RATE_VALUE <= 32'h0000_0000;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                // Pin high: quick recovery stops digital only, full mode also stops DAC, clock input and DAC ref, not sync out
                DIG_PD[i] <= act_ch_r[i][`C_PD_DIG] | pd_s2_r;
                CH_MOD_TYPE[i*2 +: 2] <= act_ch_r[i][`C_MOD_HI:`C_MOD_LO];
                SWEEP_EN[i] <= act_ch_r[i][`C_SWEEP_EN];
                NO_DWELL[i] <= act_ch_r[i][`C_SWEEP_EN] & act_ch_r[i][`C_NO_DWELL];
                MATCH_PIPE[i] <= act_glob_r[`G_MATCH_PIPE]
                    & (act_ch_r[i][`C_MOD_HI:`C_MOD_LO] == `MOD_NONE)
                    & ~act_ch_r[i][`C_SWEEP_EN];
                // Reload bit taken from the value being made active by this strobe
                RATE_LOAD[i] <= upd_any & buf_ch_r[i][`C_RELOAD_RATE];
                RATE_VALUE[i*8 +: 8] <= buf_ch_r[i][`C_RATE_HI:`C_RATE_LO];
            end
            // Only the DAC channel honours its DAC power-down
            DAC_PD <= act_ch_r[`DAC_CHANNEL][`C_PD_DAC]
                      | (pd_s2_r & act_glob_r[`G_PD_PIN_FULL]);
            CLKIN_PD <= act_glob_r[`G_PD_CLKIN] | (pd_s2_r & act_glob_r[`G_PD_PIN_FULL]);
            DACREF_PD <= act_glob_r[`G_PD_DACREF] | (pd_s2_r & act_glob_r[`G_PD_PIN_FULL]);
            SYNC_OUT_PD <= act_glob_r[`G_PD_SYNC];
            PROFILE_PIN_CONFIG <= act_f1_r[`F1_PROF_CFG_HI:`F1_PROF_CFG_LO];
            // One-hot: bit k set means 2^(k+1) levels, so 16 levels fits in four bits
            MOD_LEVELS <= 4'h1 << act_f1_r[`F1_LEVEL_HI:`F1_LEVEL_LO];
            TEST_TONE_MODE <= act_glob_r[`G_OPMODE];
            case (act_f1_r[`F1_RAMP_HI:`F1_RAMP_LO])
                `RAMP_P23: begin
                    RAMP_ACTIVE <= prof_s2_r[2];
                    RAMP_UP <= prof_s2_r[3];
                end
                `RAMP_P3: begin
                    RAMP_ACTIVE <= 1'b1;
                    RAMP_UP <= prof_s2_r[3];
                end
                `RAMP_SDIO: begin
                    RAMP_ACTIVE <= sdio_s2_r[1] | sdio_s2_r[2];
                    RAMP_UP <= sdio_s2_r[3];
                end
                default: begin
                    RAMP_ACTIVE <= 1'b0;
                    RAMP_UP <= 1'b0;
                end
            endcase
        end
    end
endmodule // dds_channel_mode_control

// ==== tb/dds_mode_chk_sva.sv ====
// Port-level assertions for the channel mode control block
// Assumes binding to the top module; names match its ports
`timescale 1ns/1ps
module dds_mode_chk (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire [31:0] WB_DAT_O,
    input wire PWR_DOWN_PIN,
    input wire [3:0] DIG_PD,
    input wire DAC_PD,
    input wire [3:0] MATCH_PIPE,
    input wire [7:0] CH_MOD_TYPE,
    input wire [3:0] SWEEP_EN,
    input wire [3:0] MOD_LEVELS,
    input wire [2:0] PROFILE_PIN_CONFIG,
    input wire [3:0] RATE_LOAD
);
    wire [3:0] moded = {|CH_MOD_TYPE[7:6], |CH_MOD_TYPE[5:4], |CH_MOD_TYPE[3:2], |CH_MOD_TYPE[1:0]};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence s_ans; WB_ACK_O ##1 !WB_ACK_O; endsequence
    a_ack_once: assert property (s_req |=> s_ans) else $error("ack not a single pulse");
    a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    a_level_set: assert property ($onehot(MOD_LEVELS))
        else $error("bad level count");
    a_pin_down: assert property (PWR_DOWN_PIN [*4] |=> DIG_PD == 4'hF)
        else $error("pin power down ignored");
    a_match_tone: assert property (!(|(MATCH_PIPE & (moded | SWEEP_EN))))
        else $error("matched delay outside single tone");
    a_rst_clear: assert property ($past(RST) |-> DIG_PD == 4'h0 && !DAC_PD
        && MATCH_PIPE == 4'h0 && PROFILE_PIN_CONFIG == 3'h0) else $error("reset value wrong");
    a_load_pulse: assert property (RATE_LOAD != 4'h0 |=> RATE_LOAD == 4'h0)
        else $error("rate load longer than one cycle");
endmodule // dds_mode_chk
bind dds_channel_mode_control dds_mode_chk u_chk (.*);

// ==== tb/dds_pin_driver.sv ====
// External controller model: produces the update strobe pin
// Assumes go is a one-cycle request on clk
`timescale 1ns/1ps
module dds_pin_driver (
    input wire clk,
    input wire go,
    output logic io_update
);
    int n = 0;
    initial io_update = 1'b0;
    // Held four cycles so the two-stage synchroniser cannot miss it
    always @(posedge clk) begin
        n <= go ? 4 : (n > 0 ? n - 1 : 0);
        io_update <= go || n > 1;
    end
endmodule // dds_pin_driver

// ==== tb/test_dds_channel_mode_control.sv ====
// Self-checking bench for the channel mode control block
// Assumes the bound checker and the pin driver model
`timescale 1ns/1ps
module test_dds_channel_mode_control;
    logic CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, PWR_DOWN_PIN = 0, go = 0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'hF, PROFILE = 4'h0, SDIO = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0000_0000, q, d;
    wire [31:0] WB_DAT_O, RATE_VALUE;
    wire WB_ACK_O, IO_UPDATE, DAC_PD, CLKIN_PD, DACREF_PD, SYNC_OUT_PD, TEST_TONE_MODE;
    wire RAMP_ACTIVE, RAMP_UP;
    wire [3:0] PH_ACC_ZERO, SW_ACC_ZERO, DIG_PD, MOD_LEVELS, SWEEP_EN, NO_DWELL, MATCH_PIPE;
    wire [3:0] RATE_LOAD;
    wire [2:0] PROFILE_PIN_CONFIG;
    wire [7:0] CH_MOD_TYPE;
    int error_cnt = 0, n_tests = 0, n_ph = 0, n_rl = 0, i;
    int m[0:9] = '{default: 0};
    int act[0:9] = '{default: 0};
    dds_channel_mode_control u_dut (.*);
    dds_pin_driver u_drv (.clk(CLK), .go(go), .io_update(IO_UPDATE));
    initial forever #20 CLK = ~CLK;
    always @(posedge CLK) begin
        n_ph <= n_ph + (PH_ACC_ZERO == 4'hF);
        n_rl <= n_rl + $countones(RATE_LOAD);
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
        @(posedge CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, w, a, dd};
        do @(posedge CLK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
        if (w && (a < 8'h08 || (a >= 8'h10 && a < 8'h20))) m[a >> 2] = dd;
    endtask
    // Settling margin covers synchroniser, copy and output register
    task upd;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        repeat (10) @(posedge CLK);
        act = m;
    endtask
    function logic [1:0] ramp(int md);
        case (md)
            0: return 2'b00;
            1: return {PROFILE[2], PROFILE[3]};
            2: return {1'b1, PROFILE[3]};
            default: return {SDIO[1] | SDIO[2], SDIO[3]};
        endcase
    endfunction
    task report_and_stop;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        error_cnt++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'hb2ef));
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        chk(MOD_LEVELS, 1);
        chk({DIG_PD, DAC_PD, MATCH_PIPE, PROFILE_PIN_CONFIG, RAMP_ACTIVE}, 0);
        wb(0, 8'h04, 0); chk(q, 0);
        for (i = 0; i < 8; i++) begin
            PROFILE <= $urandom;
            SDIO <= $urandom;
            d = (i << 12) | ((i & 3) << 10) | (($urandom & 3) << 8);
            wb(1, 8'h04, d); chk(PROFILE_PIN_CONFIG, act[1] >> 12);
            upd; chk(PROFILE_PIN_CONFIG, i);
            chk(MOD_LEVELS, 1 << ((d >> 8) & 3));
            chk({RAMP_ACTIVE, RAMP_UP}, ramp(i & 3));
            wb(0, 8'h04, 0); chk(q, d);
        end
        wb(1, 8'h00, 32'h0000_037F);
        upd;
        repeat (4) @(posedge CLK);
        chk({PH_ACC_ZERO, SW_ACC_ZERO}, 8'hFF);
        chk({CLKIN_PD, DACREF_PD, SYNC_OUT_PD, TEST_TONE_MODE, MATCH_PIPE}, 8'hFF);
        wb(1, 8'h00, 0);
        upd;
        d = n_ph;
        wb(1, 8'h00, 1);
        upd; chk(n_ph - d, 1);
        wb(1, 8'h00, 32'h0000_0200);
        for (i = 0; i < 4; i++) wb(1, 8'(16 + 4 * i), ($urandom & 32'h00FE_003F) | 32'h0001_0040);
        upd;
        d = n_rl;
        upd; chk(n_rl - d, 4);
        for (i = 0; i < 4; i++) begin
            chk(CH_MOD_TYPE[2 * i +: 2], (act[4 + i] >> 2) & 3);
            chk({SWEEP_EN[i], NO_DWELL[i], DIG_PD[i]}, {act[4 + i][4], act[4 + i][5], act[4 + i][0]});
            chk(MATCH_PIPE[i], (act[4 + i] & 32'h0000_001C) == 0);
            wb(0, 8'(16 + 4 * i), 0); chk(q, act[4 + i]);
        end
        chk(DAC_PD, act[5][1]);
        PWR_DOWN_PIN <= 1'b1;
        repeat (6) @(posedge CLK);
        chk({DIG_PD, DAC_PD, CLKIN_PD}, {4'hF, act[5][1], 1'b0});
        wb(1, 8'h00, 32'h0000_0080);
        upd; chk({DAC_PD, CLKIN_PD, DACREF_PD}, 3'h7);
        PWR_DOWN_PIN <= 1'b0;
        repeat (6) @(posedge CLK);
        chk({DAC_PD, CLKIN_PD}, {act[5][1], 1'b0});
        wb(0, 8'h3C, 0); chk(q, 0);
        report_and_stop;
    end
endmodule // test_dds_channel_mode_control
